/* src/adt_pkg.sv */
/*
   Package for the gain-control dwell timer: register offsets, field
   positions, reset values, state encoding and timing constants.
   Assumes a 10 MHz register clock that is also the reference clock
   which the dwell interval counts.
*/
package adt_pkg;

   // Clock period of pclk in nanoseconds.
   localparam int CLK_PERIOD_NS = 100;

   // Register byte offsets.
   localparam logic [7:0] ADT_OFF_CTRL   = 8'h00;
   localparam logic [7:0] ADT_OFF_STATUS = 8'h04;
   localparam logic [7:0] ADT_OFF_COUNT  = 8'h08;

   // Control register fields.
   localparam int CTRL_AGC_OFF_BIT  = 0;
   localparam int CTRL_TRACK_ON_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Status register fields.
   localparam int ST_STATE_LSB  = 0;
   localparam int ST_ATTEN_BIT  = 4;
   localparam int ST_TRACK_BIT  = 5;
   localparam int ST_ENABLE_BIT = 6;
   localparam int ST_SEL_LSB    = 8;

   // Dwell exponent map: code 1 gives the base, each code step adds two.
   localparam int K_BASE_DOC = 11;
   localparam int K_STEP     = 2;
   localparam int CNT_W      = 24;

   // Peak-detector tracking after a gain switch, in nanoseconds (least time).
   localparam int TRACK_SWITCH_NS = 2000;
   localparam int TRACK_SWITCH_CYC = (TRACK_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Settling time after enable rise or transmit-to-receive change (least time).
   localparam int SETTLE_NS  = 100000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRK_W      = 16;

   // Gain-control states, one-hot.
   typedef enum logic [3:0] {
      ADT_ST_OFF   = 4'h1,
      ADT_ST_HIGH  = 4'h2,
      ADT_ST_LOW   = 4'h4,
      ADT_ST_DWELL = 4'h8
   } adt_state_t;

endpackage

/* src/adt_sync.sv */
/*
   Two-flop synchroniser for a group of pin inputs.
   Assumes each bit is a slow level; bits are not kept coherent with
   each other, so a multi-bit code may show a mix for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module adt_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Asynchronous input and synchronised output.
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule // adt_sync

`default_nettype wire

/* src/adt_agc_dwell_timer.sv */
/*
   Gain-control sequencer with dwell timer and APB register slave.
   Assumes pclk is the crystal reference, the comparator flags, enable,
   transmit select and hold-select pins are asynchronous levels, and an
   APB master on pclk.
*/
// Notes on behaviour
// RULE1: Select code 000 disables gain control and holds high gain.
// RULE2: Codes 001 to 111 map to K of 11,13,15,...,23 ascending.
// RULE3: Dwell lasts exactly two to the K reference clock cycles.
// RULE4: In high gain, upper threshold reached engages the attenuator.
// RULE5: Below lower threshold starts dwell; expiry returns high gain if still below.
// RULE6: Select pin 2 is the code MSB, pin 0 the LSB.
// RULE7: Controller picks dwell of at least two Manchester bit periods.
// RULE8: Controller picks dwell longer than longest NRZ identical run.
// RULE9: Controller computes K from 3.3 log10 of dwell times frequency, rounds up odd.
// RULE10: Every gain switch requests temporary peak-detector tracking.
// RULE11: Enable rise or transmit-to-receive change forces tracking until settled.
// RULE12: Enable low means shutdown with gain control inactive.
// RULE13: Leaving shutdown starts high gain, counter cleared, selects sampled synchronously.
`timescale 1ns/1ps
`default_nettype none

module adt_agc_dwell_timer
   import adt_pkg::*;
#(
   parameter int K_BASE      = K_BASE_DOC,
   parameter int TRACK_CYCLES = TRACK_SWITCH_CYC,
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Device pins.
   input  wire logic        enable_pin,
   input  wire logic        tx_rx_sel,
   input  wire logic        gain_hold_sel_bit2,
   input  wire logic        gain_hold_sel_bit1,
   input  wire logic        gain_hold_sel_bit0,
   // Signal-strength comparators.
   input  wire logic        rssi_above_upper,
   input  wire logic        rssi_below_lower,
   // Attenuator and peak-detector control.
   output var  logic        lna_atten_on,
   output var  logic        peak_track_req,
   output var  logic        agc_active
);

   logic [6:0]         pins_s;
   logic               en_s;
   logic               tr_s;
   logic               above_s;
   logic               below_s;
   logic [2:0]         sel_s;
   logic               en_d_r;
   logic               tr_d_r;
   logic [1:0]         ctrl_r;
   adt_state_t         state_r;
   adt_state_t         state_nxt;
   logic [CNT_W-1:0]   cnt_r;
   logic [CNT_W-1:0]   dwell_last;
   logic [TRK_W-1:0]   trk_r;
   logic               agc_off;
   logic               gain_switch;
   logic               wr_en;
   logic               setup;

   // Dwell exponent for a select code; code 000 yields the base and is unused.
   // RULE2: odd exponent map
   function automatic logic [4:0] k_of(input logic [2:0] code);
      int k;
      k = K_BASE;
      if (code != 3'h0) begin
         k = K_BASE + K_STEP * (int'(code) - 1);
      end
      return k[4:0];
   endfunction

   // All pins pass two flops before any logic reads them.
   adt_sync #(
      .W (7)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({enable_pin, tx_rx_sel, rssi_above_upper, rssi_below_lower,
                 gain_hold_sel_bit2, gain_hold_sel_bit1, gain_hold_sel_bit0}),
      .q       (pins_s)
   );

   // Unpack the synchronised pins.
   // RULE6: pin two is MSB
   assign sel_s   = pins_s[2:0];
   assign below_s = pins_s[3];
   assign above_s = pins_s[4];
   assign tr_s    = pins_s[5];
   assign en_s    = pins_s[6];

   // RULE1: code zero disables
   assign agc_off = (sel_s == 3'h0) || ctrl_r[CTRL_AGC_OFF_BIT];

   // RULE3: last count of interval
   assign dwell_last = CNT_W'((25'h1 << k_of(sel_s)) - 25'h1);

   // Next gain state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ADT_ST_OFF: begin
            // RULE13: start in high gain
            state_nxt = ADT_ST_HIGH;
         end
         ADT_ST_HIGH: begin
            // RULE4: upper threshold attenuates
            if (!agc_off && above_s) begin
               state_nxt = ADT_ST_LOW;
            end
         end
         ADT_ST_LOW: begin
            // RULE5: start dwell timer
            if (agc_off) begin
               state_nxt = ADT_ST_HIGH;
            end else if (below_s) begin
               state_nxt = ADT_ST_DWELL;
            end
         end
         ADT_ST_DWELL: begin
            // RULE5: expiry rechecks level
            if (agc_off) begin
               state_nxt = ADT_ST_HIGH;
            end else if (!below_s) begin
               state_nxt = ADT_ST_LOW;
            end else if (cnt_r == dwell_last) begin
               state_nxt = ADT_ST_HIGH;
            end
         end
         default: begin
            state_nxt = ADT_ST_OFF;
         end
      endcase
   end

   // Gain state register; enable low forces shutdown.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ADT_ST_OFF;
      end else if (!en_s) begin
         // RULE12: shutdown when disabled
         state_r <= ADT_ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Dwell counter runs only while dwelling, cleared otherwise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else if (!en_s || state_r != ADT_ST_DWELL || state_nxt != ADT_ST_DWELL) begin
         // RULE13: counter cleared
         cnt_r <= '0;
      end else begin
         // RULE3: count dwell cycles
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   // A switch is any move into or out of the attenuated states, except the drop to shutdown.
   assign gain_switch = en_s && ((state_r == ADT_ST_HIGH) != (state_nxt == ADT_ST_HIGH))
                        && (state_r != ADT_ST_OFF);

   // Edge history for enable and transmit select.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_d_r <= 1'b0;
         tr_d_r <= 1'b0;
      end else begin
         en_d_r <= en_s;
         tr_d_r <= tr_s;
      end
   end

   // Tracking timer; the longer settle load wins over a switch load.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trk_r <= '0;
      end else if (!en_s) begin
         trk_r <= '0;
      end else if ((en_s && !en_d_r) || (tr_d_r && !tr_s)) begin
         // RULE11: settle after enable
         trk_r <= TRK_W'(SETTLE_CYCLES);
      end else if (gain_switch && trk_r < TRK_W'(TRACK_CYCLES)) begin
         // RULE10: track on switch
         trk_r <= TRK_W'(TRACK_CYCLES);
      end else if (trk_r != '0) begin
         trk_r <= trk_r - TRK_W'(1);
      end
   end

   // Outputs are decoded from flops: state, tracking timer, control and synchronised pins.
   assign lna_atten_on   = (state_r == ADT_ST_LOW) || (state_r == ADT_ST_DWELL);
   assign agc_active     = en_s && !agc_off && (state_r != ADT_ST_OFF);
   assign peak_track_req = en_s && ((trk_r != '0) || ctrl_r[CTRL_TRACK_ON_BIT]);

   // APB phases; the slave answers in the first access cycle.
   assign setup   = psel && !penable;
   assign wr_en   = psel && penable && pwrite;
   assign pready  = psel && penable;

   // Control register write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_en && paddr == ADT_OFF_CTRL) begin
         ctrl_r <= pwdata[1:0];
      end
   end

   // Read data and error are captured in the setup cycle so they leave flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
         if (paddr == ADT_OFF_CTRL) begin
            prdata[1:0] <= ctrl_r;
         end else if (paddr == ADT_OFF_STATUS) begin
            prdata[ST_STATE_LSB +: 4]  <= state_r;
            prdata[ST_ATTEN_BIT]       <= lna_atten_on;
            prdata[ST_TRACK_BIT]       <= peak_track_req;
            prdata[ST_ENABLE_BIT]      <= en_s;
            prdata[ST_SEL_LSB +: 3]    <= sel_s;
         end else if (paddr == ADT_OFF_COUNT) begin
            prdata[CNT_W-1:0] <= cnt_r;
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

endmodule // adt_agc_dwell_timer

`default_nettype wire

/* testbench/adt_rssi_model.sv */
/*
   Behavioural signal-strength comparators seen through the attenuator.
   Assumes the bench drives the received level in steps of 10 mV.
*/
`timescale 1ns/1ps
`default_nettype none

module adt_rssi_model #(
   parameter int UPPER = 128,
   parameter int LOWER = 68,
   parameter int ATTEN = 54
) (
   // Received level and attenuator state.
   input  wire logic [7:0] rf_level,
   input  wire logic       lna_atten_on,
   // Comparator flags.
   output logic            rssi_above_upper,
   output logic            rssi_below_lower
);
   logic [7:0] level;

   // The attenuator drops the indicated level by a fixed step, so a strong signal stays above the lower mark.
   assign level = lna_atten_on ? rf_level - 8'(ATTEN) : rf_level;
   assign rssi_above_upper = level >= 8'(UPPER);
   assign rssi_below_lower = level < 8'(LOWER);
endmodule // adt_rssi_model

`default_nettype wire

/* testbench/adt_properties.sv */
/*
   Port checker for the gain-control dwell timer.
   Assumes it is bound onto the top module; one clock, async reset.
*/
`timescale 1ns/1ps
`default_nettype none

module adt_properties #(
   parameter int K_BASE        = 11,
   parameter int TRACK_CYCLES  = 20,
   parameter int SETTLE_CYCLES = 1000
) (
   // Clock and reset.
   input wire logic       pclk,
   input wire logic       presetn,
   // APB.
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   // Pins.
   input wire logic       enable_pin,
   input wire logic       tx_rx_sel,
   input wire logic       gain_hold_sel_bit2,
   input wire logic       gain_hold_sel_bit1,
   input wire logic       gain_hold_sel_bit0,
   input wire logic       rssi_above_upper,
   input wire logic       rssi_below_lower,
   input wire logic       lna_atten_on,
   input wire logic       peak_track_req,
   input wire logic       agc_active
);
   wire logic [2:0] sel_code;

   // Select code as the pins form it, bit 2 first.
   assign sel_code = {gain_hold_sel_bit2, gain_hold_sel_bit1, gain_hold_sel_bit0};

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sel_zero_high: assert property ((sel_code == 3'h0)[*4] |-> !lna_atten_on && !agc_active)
      else $error("Gain control active with select code zero");
   a_shutdown_quiet: assert property ((!enable_pin)[*4] |-> !lna_atten_on && !agc_active)
      else $error("Outputs active in shutdown");
   a_atten_cause: assert property ($rose(lna_atten_on) |-> $past(rssi_above_upper, 3))
      else $error("Attenuator engaged without strong signal");
   a_release_cause: assert property ($fell(lna_atten_on) && $past(enable_pin, 3)
      |-> $past(rssi_below_lower, 3) || $past(sel_code, 3) == 3'h0)
      else $error("High gain resumed while level not below");
   a_switch_track: assert property ($changed(lna_atten_on) && enable_pin |-> ##[0:1] peak_track_req)
      else $error("No tracking on gain switch");
   a_track_span: assert property ($rose(peak_track_req) && enable_pin |-> peak_track_req[*4])
      else $error("Tracking request too short");
   a_enable_settle: assert property ($rose(enable_pin) |-> ##[2:4] peak_track_req[*8])
      else $error("No settle tracking after enable");
   a_txrx_settle: assert property ($fell(tx_rx_sel) && enable_pin |-> ##[2:4] peak_track_req[*8])
      else $error("No settle tracking after receive select");
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("Access phase without ready");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h08 |-> pslverr)
      else $error("Unmapped access without error");

   // Main scenarios reached.
   c_atten_on: cover property ($rose(lna_atten_on));
   c_atten_off: cover property ($fell(lna_atten_on));
   c_bus_error: cover property (psel && penable && pslverr);
endmodule // adt_properties

bind adt_agc_dwell_timer adt_properties #(.K_BASE(K_BASE), .TRACK_CYCLES(TRACK_CYCLES),
   .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
   .enable_pin, .tx_rx_sel, .gain_hold_sel_bit2, .gain_hold_sel_bit1, .gain_hold_sel_bit0,
   .rssi_above_upper, .rssi_below_lower, .lna_atten_on, .peak_track_req, .agc_active);

`default_nettype wire

/* testbench/adt_agc_dwell_timer_bench.sv */
/*
   Self-checking bench for the gain-control dwell timer.
   Assumes the comparator model stands in front of the block; dwell is shortened with K_BASE of 1.
*/
`timescale 1ns/1ps
`default_nettype none

module adt_agc_dwell_timer_bench;
   import adt_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, enable_pin, tx_rx_sel, sl;
   logic        pready, pslverr, above, below, atten, track, active;
   logic [2:0]  sel;
   logic [7:0]  paddr, rf_level;
   logic [31:0] pwdata, prdata, rdata;
   int          fails = 0, num_checks = 0, cyc = 0, n;
   int          dw[8];

   adt_agc_dwell_timer #(.K_BASE(1), .TRACK_CYCLES(4), .SETTLE_CYCLES(10)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin, .tx_rx_sel,
      .gain_hold_sel_bit2(sel[2]), .gain_hold_sel_bit1(sel[1]), .gain_hold_sel_bit0(sel[0]),
      .rssi_above_upper(above), .rssi_below_lower(below), .lna_atten_on(atten),
      .peak_track_req(track), .agc_active(active));
   adt_rssi_model model (.rf_level, .lna_atten_on(atten), .rssi_above_upper(above), .rssi_below_lower(below));

   // Free-running 10 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // A hang is cut short well beyond the longest dwell sweep.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // One APB transfer; the request is held until ready is seen at an edge.
   // An idle edge follows so that a second call never drives psel twice at one instant.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      sl = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Counts edges until the attenuator reaches the wanted level.
   task automatic wait_atten(input logic want, output int k);
      k = 0;
      while (atten !== want && k < 20000) begin
         @(posedge pclk);
         k++;
      end
   endtask

   task automatic t_regs;
      apb(1'b0, ADT_OFF_CTRL, 32'h0);
      check(rdata, 32'(CTRL_RESET));
      apb(1'b0, 8'h0C, 32'h0);
      check(32'(sl), 32'h1);
      // An asymmetric code, so that a swapped bit order shows.
      sel <= 3'h6;
      tick(4);
      apb(1'b0, ADT_OFF_STATUS, 32'h0);
      check(32'(rdata[10:8]), 32'h6);
      check(32'(rdata[3:0]), 32'(ADT_ST_HIGH));
   endtask

   task automatic t_dwell;
      for (int c = 1; c < 8; c++) begin
         sel <= 3'(c);
         rf_level <= 8'hC8;
         wait_atten(1'b1, n);
         check(32'(n), 32'h4);
         tick(1);
         check(32'(track), 32'h1);
         rf_level <= 8'h64;
         wait_atten(1'b0, dw[c]);
         // Three edges reach the state and one more samples it, so four add to the dwell.
         check(32'(dw[c]), 32'((1 << (2 * c - 1)) + 4));
         tick(8);
      end
   endtask

   task automatic t_recheck;
      sel <= 3'h2;
      rf_level <= 8'hC8;
      wait_atten(1'b1, n);
      rf_level <= 8'h64;
      tick(5);
      rf_level <= 8'hC8;
      tick(20);
      check(32'(atten), 32'h1);
      rf_level <= 8'h64;
      wait_atten(1'b0, n);
      check(32'(n), 32'(dw[2]));
      tick(8);
   endtask

   task automatic t_disable;
      sel <= 3'h0;
      rf_level <= 8'hC8;
      tick(20);
      check(32'(atten), 32'h0);
      check(32'(active), 32'h0);
      rf_level <= 8'h64;
      sel <= 3'h1;
      apb(1'b1, ADT_OFF_CTRL, 32'h1);
      apb(1'b0, ADT_OFF_CTRL, 32'h0);
      check(rdata, 32'h1);
      rf_level <= 8'hC8;
      tick(20);
      check(32'(atten), 32'h0);
      check(32'(active), 32'h0);
      rf_level <= 8'h64;
      apb(1'b1, ADT_OFF_CTRL, 32'h0);
   endtask

   task automatic t_enable;
      enable_pin <= 1'b0;
      tick(6);
      check(32'(active), 32'h0);
      enable_pin <= 1'b1;
      tick(5);
      check(32'(track), 32'h1);
      check(32'(atten), 32'h0);
      check(32'(active), 32'h1);
      tx_rx_sel <= 1'b1;
      tick(20);
      check(32'(track), 32'h0);
      tx_rx_sel <= 1'b0;
      tick(5);
      check(32'(track), 32'h1);
   endtask

   // Reset for five cycles, then each scenario in turn.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      enable_pin = 1'b1;
      tx_rx_sel = 1'b0;
      sel = 3'h1;
      rf_level = 8'h64;
      tick(5);
      presetn <= 1'b1;
      tick(20);
      t_regs();
      t_dwell();
      t_recheck();
      t_disable();
      t_enable();
      complete_run();
   end
endmodule // adt_agc_dwell_timer_bench

`default_nettype wire
